// *** logic/tx_hdlc_overhead_packetizer.sv ***
`timescale 1ns/1ps
// Operation
// [R1] FIFO stores 256 bytes, each with a packet end tag; byte based.
// [R2] Status shows empty, space at or above threshold, and full.
// [R3] Write to a full FIFO is dropped and sets overflow.
// [R4] Packet processor reading an empty FIFO sets underflow.
// [R5] After packet end, fill follows unless two bytes queued and start enabled.
// [R6] Reading an empty FIFO mid packet sends an abort.
// [R7] Fill continues until two bytes queued and packet start enabled.
// [R8] Reorder off: first bit is data bit 0; on: first is bit 7.
// [R9] FCS is CRC-16 with generator x16+x12+x5+1 over whole packet.
// [R10] Normally the CRC is inverted and appended.
// [R11] Error insertion appends the CRC without inversion.
// [R12] FCS disabled appends no check sequence.
// [R13] Inside a packet a zero follows every five consecutive ones.
// [R14] No stuffing during fill periods.
// [R15] Flag fill sends at least two flags until packet start.
// [R16] Ones fill sends end flag, at least 15 ones, then start flag.
// [R17] Queued data between packets gives exactly two flags between them.
// [R18] Abort sends FFh, then fill until next packet start.
// [R19] Inversion flips every bit after all packet processing.
// [R20] Stored byte holds first sent bit in bit 0, last in bit 7.
// [R21] Each byte is serialised most significant bit first.
// [R22] FIFO usable from register side while line slots stand still, and back.
// [R23] Flags are 01111110 and are never stuffed.
// [R24] Write side on bus clock, read side on line slots, status kept coherent.
module tx_hdlc_overhead_packetizer
	import tx_hdlc_pkg::*;
(
	input wire logic ref_clk, // System clock, 100 MHz
	input wire logic reset, // Synchronous reset, active high
	input wire logic [3:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [3:0] avs_byteenable, // Byte lanes of a write
	input wire logic [31:0] avs_writedata, // Write data
	output logic [31:0] avs_readdata, // Read data, valid with waitrequest low
	output logic avs_waitrequest, // Low for one cycle to end a request
	input wire logic slot_en, // Overhead bit slot, one-cycle pulse
	output logic line_bit, // Serial HDLC bit for the slot
	output logic line_bit_valid, // Pulse: line_bit belongs to last slot
	output logic line_in_fill // Level: inter-frame fill being sent
);

	// ***************************************************************
	// Declarations
	// ***************************************************************
	logic [8:0] fifo_mem [FIFO_DEPTH];
	logic [PTR_W-1:0] wr_ptr_q;
	logic [PTR_W-1:0] rd_ptr_q;
	logic [8:0] level;
	logic fifo_empty;
	logic fifo_full;
	logic space_ok;
	logic [CTRL_W-1:0] ctrl_q;
	logic [THRESH_W-1:0] thresh_q;
	logic overflow_q;
	logic underflow_q;
	logic wait_q;
	logic [31:0] rdata_q;
	logic bus_write;
	logic bus_read;
	logic data_write;
	logic stat_clear;
	tx_state_t state_q;
	tx_state_t state_d;
	logic [1:0] fill_cnt_q;
	logic [1:0] fill_cnt_d;
	logic [15:0] crc_q;
	logic [15:0] crc_d;
	logic [15:0] fcs_out;
	logic [7:0] sh_q;
	logic [3:0] left_q;
	logic stuff_en_q;
	logic [2:0] ones_q;
	logic stuff_now;
	logic need_byte;
	logic [7:0] nb;
	logic nb_stuff;
	logic fifo_rd;
	logic uflow_evt;
	logic start_ok;
	logic [7:0] head_byte;
	logic [7:0] ordered;
	logic cur_bit;
	logic cur_stuff;
	logic out_bit;

	// ***************************************************************
	// Functions
	// ***************************************************************
	// Bitwise CRC over one byte, first sent bit in [7]
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		logic fb;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			fb = r[15] ^ b[i];
			r = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000); // R9
		end
		return r;
	endfunction

	// ***************************************************************
	// Register bus slave
	// ***************************************************************
	// One wait cycle on every access; answer is registered
	assign bus_write = avs_write && !wait_q;
	assign bus_read = avs_read && !wait_q;
	assign data_write = bus_write && (avs_address[3:2] == ADDR_DATA[3:2]) && avs_byteenable[0];
	assign stat_clear = bus_write && (avs_address[3:2] == ADDR_STATUS[3:2]) && avs_byteenable[0];

	// Waitrequest drops for exactly one cycle per request
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wait_q <= 1'b1;
		end else if ((avs_read || avs_write) && wait_q) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= 1'b1;
		end
	end

	// Read data loaded in the wait cycle, presented while waitrequest is low
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read && wait_q) begin
			case (avs_address[3:2])
				ADDR_CTRL[3:2]: rdata_q <= {26'h0000000, ctrl_q};
				ADDR_THRESH[3:2]: rdata_q <= {23'h000000, thresh_q};
				ADDR_STATUS[3:2]: begin
					rdata_q <= 32'h0000_0000;
					rdata_q[STAT_EMPTY] <= fifo_empty; // R2
					rdata_q[STAT_SPACE] <= space_ok; // R2
					rdata_q[STAT_FULL] <= fifo_full; // R2
					rdata_q[STAT_OVERFLOW] <= overflow_q;
					rdata_q[STAT_UNDERFLOW] <= underflow_q;
					rdata_q[STAT_IN_FILL] <= line_in_fill;
					rdata_q[STAT_LEVEL_LSB +: 9] <= level;
				end
				default: rdata_q <= 32'h0000_0000; // Data port reads zero
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	// Control and threshold registers, low lanes only carry bits
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ctrl_q <= CTRL_RESET;
			thresh_q <= THRESH_RESET;
		end else if (bus_write) begin
			if (avs_address[3:2] == ADDR_CTRL[3:2] && avs_byteenable[0]) begin
				ctrl_q <= avs_writedata[CTRL_W-1:0];
			end
			if (avs_address[3:2] == ADDR_THRESH[3:2]) begin
				if (avs_byteenable[0]) begin
					thresh_q[7:0] <= avs_writedata[7:0];
				end
				if (avs_byteenable[1]) begin
					thresh_q[8] <= avs_writedata[8];
				end
			end
		end
	end

	// Sticky error flags, write one to clear, a new event wins
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			overflow_q <= 1'b0;
			underflow_q <= 1'b0;
		end else begin
			if (data_write && fifo_full) begin
				overflow_q <= 1'b1; // R3
			end else if (stat_clear && avs_writedata[STAT_OVERFLOW]) begin
				overflow_q <= 1'b0;
			end
			// Decode runs every cycle; only a real byte fetch may count
			if (need_byte && uflow_evt) begin
				underflow_q <= 1'b1; // R4
			end else if (stat_clear && avs_writedata[STAT_UNDERFLOW]) begin
				underflow_q <= 1'b0;
			end
		end
	end

	// ***************************************************************
	// Transmit FIFO
	// ***************************************************************
	// Single clock; the slot strobe is only an enable, so either side
	// works while the other is idle and fill status needs no crossing
	assign level = wr_ptr_q - rd_ptr_q; // R24
	assign fifo_empty = (level == 9'h000); // R2
	assign fifo_full = (level == FIFO_DEPTH_W); // R2
	assign space_ok = ((FIFO_DEPTH_W - level) >= thresh_q); // R2
	assign head_byte = fifo_mem[rd_ptr_q[7:0]][7:0];

	// Storage with packet end tag in bit 8
	always_ff @(posedge ref_clk) begin
		if (data_write && !fifo_full) begin
			fifo_mem[wr_ptr_q[7:0]] <= {avs_writedata[END_BIT], avs_writedata[7:0]}; // R1
		end
	end

	// Pointers; a write while full is dropped
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wr_ptr_q <= 9'h000;
			rd_ptr_q <= 9'h000;
		end else begin
			if (data_write && !fifo_full) begin
				wr_ptr_q <= wr_ptr_q + 9'h001; // R3 R22
			end
			// Read only at a byte boundary, else the pointer runs away
			if (need_byte && fifo_rd) begin
				rd_ptr_q <= rd_ptr_q + 9'h001; // R22
			end
		end
	end

	// ***************************************************************
	// Packet processor: byte selection
	// ***************************************************************
	// Bit 0 of a stored byte is sent first unless reordering is on
	generate
		for (genvar i = 0; i < 8; i++) begin : g_order
			assign ordered[i] = ctrl_q[CTRL_REORDER] ? head_byte[i] : head_byte[7-i]; // R8 R20
		end
	endgenerate

	assign start_ok = ctrl_q[CTRL_PKT_START] && (level >= START_MIN_BYTES); // R7
	assign fcs_out = ctrl_q[CTRL_FCS_ERR] ? crc_q : ~crc_q; // R10 R11
	assign stuff_now = stuff_en_q && (ones_q == STUFF_RUN);
	assign need_byte = slot_en && !stuff_now && (left_q == 4'h0);

	// Next byte and next state, decoded every cycle, taken only at a byte boundary
	always_comb begin
		state_d = state_q;
		fill_cnt_d = fill_cnt_q;
		crc_d = crc_q;
		nb = FLAG_BYTE;
		nb_stuff = 1'b0;
		fifo_rd = 1'b0;
		uflow_evt = 1'b0;
		case (state_q)
			ST_FILL: begin
				if (start_ok && fill_cnt_q >= FILL_MIN_BYTES) begin
					nb = FLAG_BYTE; // R15 R16 R23
					crc_d = CRC_INIT;
					state_d = ST_DATA;
				end else begin
					nb = ctrl_q[CTRL_FILL_ONES] ? ONES_BYTE : FLAG_BYTE; // R14 R15 R16
					if (fill_cnt_q != 2'h3) begin
						fill_cnt_d = fill_cnt_q + 2'h1;
					end
				end
			end
			ST_SOF: begin
				nb = FLAG_BYTE; // R17 R23
				crc_d = CRC_INIT;
				state_d = ST_DATA;
			end
			ST_DATA: begin
				if (fifo_empty) begin
					nb = ABORT_BYTE; // R6 R18
					uflow_evt = 1'b1; // R4
					fill_cnt_d = 2'h0;
					state_d = ST_FILL; // R18
				end else begin
					nb = ordered;
					nb_stuff = 1'b1; // R13
					fifo_rd = 1'b1;
					crc_d = crc_byte(crc_q, ordered); // R9
					if (fifo_mem[rd_ptr_q[7:0]][END_BIT]) begin
						state_d = ctrl_q[CTRL_FCS_EN] ? ST_FCS_HI : ST_EOF; // R12
					end
				end
			end
			ST_FCS_HI: begin
				nb = fcs_out[15:8]; // R10
				nb_stuff = 1'b1; // R13
				state_d = ST_FCS_LO;
			end
			ST_FCS_LO: begin
				nb = fcs_out[7:0]; // R10
				nb_stuff = 1'b1; // R13
				state_d = ST_EOF;
			end
			ST_EOF: begin
				nb = FLAG_BYTE; // R23
				if (start_ok) begin
					state_d = ST_SOF; // R17
				end else begin
					state_d = ST_FILL; // R5
					fill_cnt_d = ctrl_q[CTRL_FILL_ONES] ? 2'h0 : 2'h1; // R15 R16
				end
			end
			default: begin
				state_d = ST_FILL;
				fill_cnt_d = 2'h0;
			end
		endcase
	end

	// Framing state advances once per byte
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q <= ST_FILL;
			fill_cnt_q <= 2'h0;
			crc_q <= CRC_INIT;
		end else if (need_byte) begin
			state_q <= state_d;
			fill_cnt_q <= fill_cnt_d;
			crc_q <= crc_d;
		end
	end

	// ***************************************************************
	// Serialiser and zero insertion
	// ***************************************************************
	// A new byte's first bit leaves in the same slot it is loaded
	assign cur_bit = (left_q == 4'h0) ? nb[7] : sh_q[7]; // R21
	assign cur_stuff = (left_q == 4'h0) ? nb_stuff : stuff_en_q;

	// Pending stuff bit goes out before the next byte is fetched
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sh_q <= 8'h00;
			left_q <= 4'h0;
			stuff_en_q <= 1'b0;
			ones_q <= 3'h0;
		end else if (slot_en) begin
			if (stuff_now) begin
				ones_q <= 3'h0; // R13
			end else begin
				if (left_q == 4'h0) begin
					sh_q <= {nb[6:0], 1'b0}; // R21
					left_q <= BYTE_BITS - 4'h1;
					stuff_en_q <= nb_stuff;
				end else begin
					sh_q <= {sh_q[6:0], 1'b0}; // R21
					left_q <= left_q - 4'h1;
				end
				if (cur_stuff && cur_bit) begin
					ones_q <= ones_q + 3'h1; // R13
				end else begin
					ones_q <= 3'h0; // R14 R23
				end
			end
		end
	end

	// ***************************************************************
	// Line outputs
	// ***************************************************************
	assign out_bit = stuff_now ? 1'b0 : cur_bit;

	// Inversion is the very last step before the slot
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			line_bit <= 1'b0;
			line_bit_valid <= 1'b0;
		end else begin
			line_bit_valid <= slot_en;
			if (slot_en) begin
				line_bit <= out_bit ^ ctrl_q[CTRL_INVERT]; // R19
			end
		end
	end

	// Fill indication follows the framing state
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			line_in_fill <= 1'b1;
		end else begin
			line_in_fill <= (state_q == ST_FILL); // R5
		end
	end

	assign avs_waitrequest = wait_q;
	assign avs_readdata = rdata_q;

endmodule

// *** logic/tx_hdlc_pkg.sv ***
package tx_hdlc_pkg;

	// ***************************************************************
	// FIFO geometry
	// ***************************************************************
	localparam int FIFO_DEPTH = 256;
	localparam int PTR_W = 9;
	localparam logic [8:0] FIFO_DEPTH_W = 9'h100;
	localparam int END_BIT = 8;

	// ***************************************************************
	// Register map (byte addresses, one 32-bit word each)
	// ***************************************************************
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_THRESH = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_DATA = 4'hc;

	// Control register fields
	localparam int CTRL_FCS_EN = 0;
	localparam int CTRL_FCS_ERR = 1;
	localparam int CTRL_REORDER = 2;
	localparam int CTRL_INVERT = 3;
	localparam int CTRL_FILL_ONES = 4;
	localparam int CTRL_PKT_START = 5;
	localparam int CTRL_W = 6;
	localparam logic [5:0] CTRL_RESET = 6'h01;

	// Threshold register
	localparam int THRESH_W = 9;
	localparam logic [8:0] THRESH_RESET = 9'h010;

	// Status register fields
	localparam int STAT_EMPTY = 0;
	localparam int STAT_SPACE = 1;
	localparam int STAT_FULL = 2;
	localparam int STAT_OVERFLOW = 3;
	localparam int STAT_UNDERFLOW = 4;
	localparam int STAT_IN_FILL = 5;
	localparam int STAT_LEVEL_LSB = 16;

	// ***************************************************************
	// Line coding constants
	// ***************************************************************
	localparam logic [7:0] FLAG_BYTE = 8'h7e;
	localparam logic [7:0] ABORT_BYTE = 8'hff;
	localparam logic [7:0] ONES_BYTE = 8'hff;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [2:0] STUFF_RUN = 3'h5;
	localparam logic [8:0] START_MIN_BYTES = 9'h002;
	localparam logic [1:0] FILL_MIN_BYTES = 2'h2;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	typedef enum logic [2:0] {
		ST_FILL = 3'b000,
		ST_SOF = 3'b001,
		ST_DATA = 3'b010,
		ST_FCS_HI = 3'b011,
		ST_FCS_LO = 3'b100,
		ST_EOF = 3'b101
	} tx_state_t;

endpackage

// *** verification/tx_hdlc_sva.sv ***
`timescale 1ns/1ps
module tx_hdlc_sva (
	input wire logic ref_clk, // Clock
	input wire logic reset, // Sync reset
	input wire logic [3:0] avs_address, // Address
	input wire logic avs_read, // Read
	input wire logic avs_write, // Write
	input wire logic [3:0] avs_byteenable, // Lanes
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [31:0] avs_readdata, // Read data
	input wire logic avs_waitrequest, // Wait
	input wire logic slot_en, // Slot pulse
	input wire logic line_bit, // Serial bit
	input wire logic line_bit_valid, // Bit strobe
	input wire logic line_in_fill // Fill level
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// ********
	// Bus side
	// ********
	// One-cycle answer, only ever caused by a request
	property p_bus_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus not answered");
	property p_bus_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_bus_pulse: assert property (p_bus_pulse) else $error("wait low too long");
	property p_bus_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
	a_bus_cause: assert property (p_bus_cause) else $error("answer without request");
	// Read data is zero outside the answer cycle
	property p_rdata_idle; avs_waitrequest |-> avs_readdata == 32'h0; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	// ********
	// Line side
	// ********
	// Each slot yields exactly one bit, a cycle later
	property p_slot_valid; slot_en |=> line_bit_valid; endproperty
	a_slot_valid: assert property (p_slot_valid) else $error("bit missing after slot");
	property p_no_slot; !slot_en |=> !line_bit_valid; endproperty
	a_no_slot: assert property (p_no_slot) else $error("bit without slot");
	// Without slots the line stands still
	property p_bit_hold; !line_bit_valid |-> $stable(line_bit); endproperty
	a_bit_hold: assert property (p_bit_hold) else $error("line bit moved");
	property p_fill_slot; $changed(line_in_fill) |-> $past(line_bit_valid); endproperty
	a_fill_slot: assert property (p_fill_slot) else $error("fill moved off slot");
	c_write: cover property (avs_write && !avs_waitrequest);
	c_read: cover property (avs_read && !avs_waitrequest);
	c_frame: cover property ($fell(line_in_fill));
endmodule

bind tx_hdlc_overhead_packetizer tx_hdlc_sva u_sva (.ref_clk(ref_clk), .reset(reset),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .slot_en(slot_en),
	.line_bit(line_bit), .line_bit_valid(line_bit_valid), .line_in_fill(line_in_fill));

// *** verification/slot_sink.sv ***
`timescale 1ns/1ps
module slot_sink (
	input wire logic ref_clk, // Clock
	input wire logic reset, // Sync reset
	input wire logic [1:0] gap, // Idle cycles per slot
	input wire logic line_bit, // Serial bit
	input wire logic line_bit_valid, // Bit strobe
	output logic slot_en // Slot pulse
);
	logic [1:0] cnt_q;
	logic cap_q[$];
	// Slot pacing; gap 0 gives back-to-back slots
	always_ff @(posedge ref_clk) begin
		cnt_q <= (reset || cnt_q >= gap) ? 2'h0 : cnt_q + 2'h1;
		slot_en <= !reset && cnt_q >= gap;
	end
	// Keep every bit offered, in line order
	always @(posedge ref_clk) begin
		if (line_bit_valid) begin
			cap_q.push_back(line_bit);
		end
	end
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	import tx_hdlc_pkg::*;
	logic ref_clk, reset, avs_read, avs_write, slot_en, line_bit, line_bit_valid, line_in_fill;
	logic avs_waitrequest;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rd, seed;
	logic [1:0] gap;
	logic [7:0] pkt[$];
	logic ex[$];
	logic [5:0] modes[6] = '{6'h01, 6'h03, 6'h00, 6'h05, 6'h09, 6'h11};
	int num_errors, comparisons, run, tmo;

	tx_hdlc_overhead_packetizer DUT (.ref_clk(ref_clk), .reset(reset),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .slot_en(slot_en),
		.line_bit(line_bit), .line_bit_valid(line_bit_valid), .line_in_fill(line_in_fill));
	slot_sink sink (.ref_clk(ref_clk), .reset(reset), .gap(gap), .line_bit(line_bit),
		.line_bit_valid(line_bit_valid), .slot_en(slot_en));

	// Free-running clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ********
	// Helpers
	// ********
	task automatic check(input string what, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// One clock, with a hang guard
	task automatic step(input int lim);
		@(posedge ref_clk);
		tmo++;
		if (tmo > lim) begin
			num_errors++;
			results();
		end
	endtask
	// Request held until wait is seen low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= d;
		tmo = 0;
		do step(20); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic stat(input logic [8:0] lvl, input logic [5:0] f);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check("status", {rd[24:16], rd[5:0]}, {lvl, f});
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic rand_bytes(input int n);
		repeat (n) begin
			seed = lfsr(seed);
			pkt.push_back(seed[7:0]);
		end
	endtask
	// Expected line bit; zero after five ones
	task automatic put(input logic b);
		ex.push_back(b);
		run = b ? run + 1 : 0;
		if (run == 5) begin
			ex.push_back(1'b0);
			run = 0;
		end
	endtask
	task automatic flag;
		for (int i = 7; i >= 0; i--) ex.push_back(FLAG_BYTE[i]);
		run = 0;
	endtask
	// Naive search is fine: captures stay short
	function automatic logic found();
		int j;
		for (int k = 0; k + ex.size() <= sink.cap_q.size(); k++) begin
			j = 0;
			while (j < ex.size() && sink.cap_q[k + j] === ex[j]) j++;
			if (j == ex.size()) return 1'b1;
		end
		return 1'b0;
	endfunction
	// Queue pkt with start held off, build the expected stream, then release
	task automatic frame(input logic [5:0] c, input logic ab, input int cut);
		logic [15:0] crc;
		logic b, e;
		seed = lfsr(seed);
		gap <= seed[1:0];
		bus(1'b1, ADDR_CTRL, {26'h0, c});
		sink.cap_q.delete();
		ex.delete();
		tmo = 0;
		while (sink.cap_q.size() < 32) step(400);
		crc = CRC_INIT;
		if (c[CTRL_FILL_ONES]) repeat (15) ex.push_back(1'b1);
		else repeat (2) flag();
		flag();
		foreach (pkt[i]) begin
			e = !ab && (i == cut || i == pkt.size() - 1);
			bus(1'b1, ADDR_DATA, {23'h0, e, pkt[i]});
			for (int k = 0; k < 8; k++) begin
				b = c[CTRL_REORDER] ? pkt[i][7 - k] : pkt[i][k];
				crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? CRC_POLY : 16'h0);
				put(b);
			end
			if (e) begin
				if (c[CTRL_FCS_EN]) begin
					if (!c[CTRL_FCS_ERR]) crc = ~crc;
					for (int k = 15; k >= 0; k--) put(crc[k]);
				end
				flag();
				if (i == cut && cut < pkt.size() - 1) flag();
				crc = CRC_INIT;
			end
		end
		if (ab) repeat (8) ex.push_back(1'b1);
		if (c[CTRL_INVERT]) foreach (ex[i]) ex[i] = !ex[i];
		bus(1'b1, ADDR_CTRL, {26'h0, c} | 32'h20);
		tmo = 0;
		while (!found() && tmo < 2560) step(4000);
		check("frame", found(), 1'b1);
	endtask
	// Reset, then reset values of every register
	task automatic reset_cycle;
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		bus(1'b0, ADDR_CTRL, 32'h0);
		check("ctrl", rd[5:0], CTRL_RESET);
		bus(1'b0, ADDR_THRESH, 32'h0);
		check("thresh", rd[8:0], THRESH_RESET);
		bus(1'b0, ADDR_DATA, 32'h0);
		check("data read", rd, 32'h0);
		stat(9'h0, 6'b100011);
	endtask

	// ********
	// Main sequence
	// ********
	initial begin
		reset = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_byteenable = 4'hf;
		avs_writedata = 32'h0;
		gap = 2'h0;
		seed = 32'ha672;
		num_errors = 0;
		comparisons = 0;
		reset_cycle();
		// Every mode, each packet led by stuffing-heavy bytes
		foreach (modes[m]) begin
			pkt = '{8'hff, 8'h7e};
			rand_bytes(m % 3);
			frame(modes[m], 1'b0, 255);
		end
		pkt.delete();
		rand_bytes(5);
		frame(6'h01, 1'b0, 1);
		stat(9'h0, 6'b100011);
		// Packet with no end tag runs dry
		pkt = '{8'h12, 8'h34};
		frame(6'h01, 1'b1, 255);
		stat(9'h0, 6'b110011);
		bus(1'b1, ADDR_STATUS, 32'h10);
		stat(9'h0, 6'b100011);
		// Fill to the brim with the line side starved
		bus(1'b1, ADDR_CTRL, 32'h1);
		bus(1'b1, ADDR_THRESH, 32'h2);
		pkt.delete();
		rand_bytes(255);
		foreach (pkt[i]) bus(1'b1, ADDR_DATA, {24'h0, pkt[i]});
		stat(9'hff, 6'b100000);
		bus(1'b1, ADDR_THRESH, 32'h1);
		stat(9'hff, 6'b100010);
		repeat (2) bus(1'b1, ADDR_DATA, 32'h5a);
		stat(9'h100, 6'b101100);
		bus(1'b1, ADDR_STATUS, 32'h8);
		stat(9'h100, 6'b100100);
		reset_cycle();
		results();
	end
endmodule
